// [verilog/ddm_regs.svh]
`ifndef DDM_REGS_SVH
`define DDM_REGS_SVH

// Register byte addresses on the software port.
`define DDM_ADDR_PROT_POS   8'h00
`define DDM_ADDR_REV_CFG    8'h04
`define DDM_ADDR_DOOR_POS   8'h08
`define DDM_ADDR_STATUS     8'h0c
`define DDM_ADDR_WIDTH      8'h10

// Reset values of the software-written settings.
`define DDM_PROT_POS_RST    16'h0010
`define DDM_REV_CFG_RST     3'h0

// Fields of the reopen configuration register.
`define DDM_CFG_STALL_BIT   0
`define DDM_CFG_EDGE_LSB    1
`define DDM_CFG_EDGE_MSB    2

// Edge detector settings.
`define DDM_EDGE_OFF        2'h0
`define DDM_EDGE_SINK       2'h1
`define DDM_EDGE_SOURCE     2'h2

// Positions within this distance of a limit count as at the limit.
`define DDM_LIMIT_TOL       16'h0002

// Bit positions of the status register.
`define DDM_ST_RUN          0
`define DDM_ST_AUTO         1
`define DDM_ST_LEARNED      2
`define DDM_ST_FAULT        3
`define DDM_ST_LEARNING     4
`define DDM_ST_OPEN         5
`define DDM_ST_CLOSE        6
`define DDM_ST_SLOW         7
`define DDM_ST_HOLD         8
`define DDM_ST_PROT         9
`define DDM_ST_REV          10
`define DDM_ST_CLOSED       11
`define DDM_ST_OPENED       12
`define DDM_ST_SLIM         13
`define DDM_ST_HEAVY        14
`define DDM_ST_EDGE         15

`endif

// [verilog/ddm_pkg.sv]
// Types shared by the door drive mode logic.
package ddm_pkg;

  // Operating state of the drive.
  typedef enum logic [1:0]
  {
    DDM_HALT,
    DDM_AUTO,
    DDM_HAND,
    DDM_LEARN
  } ddm_mode_e;

  // Door position, counted from the closed end.
  typedef logic [15:0] ddm_pos_t;

  // Register data word.
  typedef logic [31:0] ddm_word_t;

endpackage

// [verilog/ddm_rise.sv]
`timescale 1ns/1ps

// Rising edge detector for a group of panel toggles.
module ddm_rise #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] level_i,
  output logic      [WIDTH-1:0] rise_o
);

  // Previous level of each toggle.
  logic [WIDTH-1:0] prev_q;

  // One detector per toggle.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // Keeps the last sampled level; a toggle held at reset gives no edge.
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          prev_q[g] <= 1'b1;
        else
          prev_q[g] <= level_i[g];
      end
      // Pulses for one cycle when the toggle goes high.
      assign rise_o[g] = level_i[g] & ~prev_q[g];
    end
  endgenerate

endmodule

// [verilog/ddm_top.sv]
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "ddm_regs.svh"

// Overview of operation
// R1 - Setup position halts drive, motor unpowered
// R2 - Locked settings writable only in setup
// R3 - Run plus automatic gives normal operation
// R4 - Manual mode moves door from panel toggles
// R5 - Open/close toggle acts only in manual
// R6 - Slow-close closes door at nudging speed
// R7 - Slim-door toggle counts only in run-manual
// R8 - Weighted toggle counts only in run-manual
// R9 - Tuning toggle in setup starts width learning
// R10 - Reset press clears latched faults only
// R11 - Controller commands via four discrete inputs
// R12 - Automatic mode ignores panel motion toggles
// R13 - Protection output at adjustable pre-gate position
// R14 - Reverse request only flags, never reopens
// R15 - Reverse triggers: stall or edge, each enabled
// R16 - Closed limit after learning at closed
// R17 - Open limit after learning at open
// R18 - Indicators show learning, direction, limits, states
// R19 - Edge setting zero disables edge trigger
// R20 - Edge setting one sinking, two sourcing
// R21 - Open and close together hold door
module ddm_top (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Software register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Panel selectors and toggles, high in the named position.
  input  wire logic        sel_run_i,
  input  wire logic        sel_auto_i,
  input  wire logic        tog_open_i,
  input  wire logic        tog_close_i,
  input  wire logic        tog_slow_i,
  input  wire logic        tog_slim_i,
  input  wire logic        tog_tune_i,
  input  wire logic        tog_heavy_i,
  input  wire logic        tog_reset_i,
  // Controller command inputs.
  input  wire logic        ext_open_i,
  input  wire logic        ext_close_i,
  input  wire logic        ext_slow_i,
  input  wire logic        ext_heavy_i,
  // Drive side status.
  input  wire logic        stall_rev_i,
  input  wire logic        edge_sense_i,
  input  wire logic        fault_i,
  input  wire logic [15:0] door_pos_i,
  input  wire logic        learn_done_i,
  input  wire logic [15:0] learn_width_i,
  // Motor command outputs.
  output logic             motor_en_o,
  output logic             cmd_open_o,
  output logic             cmd_close_o,
  output logic             slow_close_o,
  output logic             slim_door_mode_o,
  output logic             heavy_door_o,
  output logic             learn_start_o,
  // Relay outputs.
  output logic             door_protection_output_o,
  output logic             door_reverse_request_o,
  output logic             closed_limit_output_o,
  output logic             open_limit_output_o,
  // Indicators.
  output logic             ind_learning_o,
  output logic             ind_learned_o,
  output logic             ind_hold_o,
  output logic             ind_edge_o,
  output logic             fault_monitor_o
);

  // Mode state and the settings written by software.
  ddm_pkg::ddm_mode_e mode_q, mode_d;
  ddm_pkg::ddm_pos_t  prot_pos_q;
  logic [2:0]         rev_cfg_q;
  ddm_pkg::ddm_pos_t  width_q;
  logic               learned_q;
  logic               fault_q;
  ddm_pkg::ddm_word_t rdata_q;
  logic [15:0]        status_q;

  // Registered copies of every output.
  logic motor_en_q, open_q, close_q, slow_q, slim_q, heavy_q, lstart_q;
  logic prot_q, rev_q, closed_q, opened_q, hold_q, edge_q;

  // Rising edges of the tuning and reset toggles.
  logic [1:0] tog_rise;

  ddm_rise #(
    .WIDTH (2)
  ) u_rise (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .level_i ({tog_reset_i, tog_tune_i}),
    .rise_o  (tog_rise)
  );

  // Named decode of the panel and register port.
  wire setup_w     = ~sel_run_i;
  wire tune_rise_w = tog_rise[0];
  wire rst_rise_w  = tog_rise[1];
  wire wr_prot_w   = wr_i & (addr_i == `DDM_ADDR_PROT_POS);
  wire wr_cfg_w    = wr_i & (addr_i == `DDM_ADDR_REV_CFG);
  wire wr_ok_w     = setup_w; // R2

  // Command source selection: panel in manual, controller in automatic.
  wire hand_w  = (mode_q == ddm_pkg::DDM_HAND);
  wire auto_w  = (mode_q == ddm_pkg::DDM_AUTO);
  wire src_open_w  = hand_w ? tog_open_i  : ext_open_i;  // R5 R11 R12
  wire src_close_w = hand_w ? tog_close_i : ext_close_i; // R5 R11 R12
  wire src_slow_w  = hand_w ? tog_slow_i  : ext_slow_i;  // R4 R12
  wire src_heavy_w = hand_w ? tog_heavy_i : ext_heavy_i; // R8 R11
  wire moving_w    = hand_w | auto_w;                    // R3 R4
  wire both_w      = src_open_w & src_close_w;           // R21
  // The reverse request never enters this path; only the controller reopens.
  wire open_d_w    = moving_w & src_open_w & ~both_w;    // R14 R21
  wire close_d_w   = moving_w & src_close_w & ~both_w;   // R21
  wire slow_d_w    = close_d_w & src_slow_w;             // R6
  wire slim_d_w    = hand_w & tog_slim_i;                // R7
  wire heavy_d_w   = moving_w & src_heavy_w;             // R8

  // Reverse request triggers.
  wire [1:0] edge_set_w = rev_cfg_q[`DDM_CFG_EDGE_MSB:`DDM_CFG_EDGE_LSB];
  wire edge_hit_w =
    ((edge_set_w == `DDM_EDGE_SINK)   & ~edge_sense_i) | // R20
    ((edge_set_w == `DDM_EDGE_SOURCE) &  edge_sense_i);  // R19 R20
  wire stall_hit_w = rev_cfg_q[`DDM_CFG_STALL_BIT] & stall_rev_i; // R15
  wire rev_d_w     = stall_hit_w | edge_hit_w;                   // R15

  // Position compares against the learned limits and the protection position.
  wire at_closed_w = learned_q & (door_pos_i <= `DDM_LIMIT_TOL);      // R16
  wire [16:0] open_reach_w = {1'b0, door_pos_i} + {1'b0, `DDM_LIMIT_TOL};
  wire at_open_w   = learned_q & (open_reach_w >= {1'b0, width_q}); // R17
  wire prot_d_w    = door_pos_i <= prot_pos_q;                      // R13

  // Status word for the indicators and software.
  logic [15:0] status_d;
  always_comb
  begin
    status_d = 16'h0000;
    status_d[`DDM_ST_RUN]      = sel_run_i;
    status_d[`DDM_ST_AUTO]     = sel_auto_i;
    status_d[`DDM_ST_LEARNED]  = learned_q;
    status_d[`DDM_ST_FAULT]    = fault_q;
    status_d[`DDM_ST_LEARNING] = (mode_q == ddm_pkg::DDM_LEARN);
    status_d[`DDM_ST_OPEN]     = open_q;
    status_d[`DDM_ST_CLOSE]    = close_q;
    status_d[`DDM_ST_SLOW]     = slow_q;
    status_d[`DDM_ST_HOLD]     = hold_q;
    status_d[`DDM_ST_PROT]     = prot_q;
    status_d[`DDM_ST_REV]      = rev_q;
    status_d[`DDM_ST_CLOSED]   = closed_q;
    status_d[`DDM_ST_OPENED]   = opened_q;
    status_d[`DDM_ST_SLIM]     = slim_q;
    status_d[`DDM_ST_HEAVY]    = heavy_q;
    status_d[`DDM_ST_EDGE]     = edge_hit_w; // R18
  end

  // Read multiplexer; unmapped addresses read as zero.
  ddm_pkg::ddm_word_t rmux_w;
  always_comb
  begin
    case (addr_i)
      `DDM_ADDR_PROT_POS: rmux_w = {16'h0000, prot_pos_q};
      `DDM_ADDR_REV_CFG:  rmux_w = {29'h0000000, rev_cfg_q};
      `DDM_ADDR_DOOR_POS: rmux_w = {16'h0000, door_pos_i};
      `DDM_ADDR_STATUS:   rmux_w = {16'h0000, status_q};
      `DDM_ADDR_WIDTH:    rmux_w = {16'h0000, width_q};
      default:            rmux_w = 32'h00000000;
    endcase
  end

  // Next operating state from the selectors and the tuning toggle.
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      ddm_pkg::DDM_HALT:
        // Tuning flipped during setup begins learning.
        if (sel_run_i)
          mode_d = sel_auto_i ? ddm_pkg::DDM_AUTO : ddm_pkg::DDM_HAND;
        else if (tune_rise_w)
          mode_d = ddm_pkg::DDM_LEARN; // R9
      ddm_pkg::DDM_LEARN:
        // Learning ends when done or when setup is left.
        if (learn_done_i | sel_run_i)
          mode_d = ddm_pkg::DDM_HALT;
      ddm_pkg::DDM_AUTO,
      ddm_pkg::DDM_HAND:
        // Any move to setup halts at once.
        if (setup_w)
          mode_d = ddm_pkg::DDM_HALT; // R1
        else
          mode_d = sel_auto_i ? ddm_pkg::DDM_AUTO : ddm_pkg::DDM_HAND;
      default:
        mode_d = ddm_pkg::DDM_HALT;
    endcase
  end

  // Mode register.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mode_q <= ddm_pkg::DDM_HALT;
    else
      mode_q <= mode_d;
  end

  // Settings written by software, accepted only in setup.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prot_pos_q <= `DDM_PROT_POS_RST;
      rev_cfg_q  <= `DDM_REV_CFG_RST;
    end
    else if (wr_ok_w)
    begin
      if (wr_prot_w)
        prot_pos_q <= wdata_i[15:0]; // R13 R2
      if (wr_cfg_w)
        rev_cfg_q  <= wdata_i[2:0];  // R15 R2
    end
  end

  // Learned width; a fresh learning clears the learned flag but keeps the old width.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      learned_q <= 1'b0;
      width_q   <= 16'h0000;
    end
    else if (mode_q == ddm_pkg::DDM_LEARN && learn_done_i)
    begin
      learned_q <= 1'b1; // R16 R17
      width_q   <= learn_width_i;
    end
    else if (mode_d == ddm_pkg::DDM_LEARN && mode_q != ddm_pkg::DDM_LEARN)
      learned_q <= 1'b0;
  end

  // Fault latch; a new fault in the reset cycle stays latched.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      fault_q <= 1'b0;
    else if (fault_i)
      fault_q <= 1'b1;
    else if (rst_rise_w)
      fault_q <= 1'b0; // R10
  end

  // Motor commands and the hold indicator, registered.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      motor_en_q <= 1'b0;
      open_q     <= 1'b0;
      close_q    <= 1'b0;
      slow_q     <= 1'b0;
      slim_q     <= 1'b0;
      heavy_q    <= 1'b0;
      hold_q     <= 1'b0;
      lstart_q   <= 1'b0;
    end
    else
    begin
      motor_en_q <= moving_w & sel_run_i; // R1 R3
      open_q     <= open_d_w;
      close_q    <= close_d_w;
      slow_q     <= slow_d_w;   // R6
      slim_q     <= slim_d_w;   // R7
      heavy_q    <= heavy_d_w;  // R8
      hold_q     <= moving_w & ~open_d_w & ~close_d_w; // R21 R18
      lstart_q   <= (mode_q == ddm_pkg::DDM_HALT) &
                    (mode_d == ddm_pkg::DDM_LEARN); // R9
    end
  end

  // Relay outputs and the edge indicator, registered.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prot_q   <= 1'b0;
      rev_q    <= 1'b0;
      closed_q <= 1'b0;
      opened_q <= 1'b0;
      edge_q   <= 1'b0;
    end
    else
    begin
      prot_q   <= prot_d_w;    // R13
      rev_q    <= rev_d_w;     // R14 R15
      closed_q <= at_closed_w; // R16
      opened_q <= at_open_w;   // R17
      edge_q   <= edge_hit_w;  // R18
    end
  end

  // Status snapshot and read data; data stand only in the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      status_q <= 16'h0000;
      rdata_q  <= 32'h00000000;
    end
    else
    begin
      status_q <= status_d;
      rdata_q  <= rd_i ? rmux_w : 32'h00000000;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata_o                  = rdata_q;
  assign motor_en_o               = motor_en_q;
  assign cmd_open_o               = open_q;
  assign cmd_close_o              = close_q;
  assign slow_close_o             = slow_q;
  assign slim_door_mode_o         = slim_q;
  assign heavy_door_o             = heavy_q;
  assign learn_start_o            = lstart_q;
  assign door_protection_output_o = prot_q;
  assign door_reverse_request_o   = rev_q;
  assign closed_limit_output_o    = closed_q;
  assign open_limit_output_o      = opened_q;
  assign ind_learning_o           = status_q[`DDM_ST_LEARNING];
  assign ind_learned_o            = learned_q;
  assign ind_hold_o               = hold_q;
  assign ind_edge_o               = edge_q;
  assign fault_monitor_o          = fault_q;

  // Checks on the outputs against their causes.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_setup_no_power: assert property ( // R1
    !sel_run_i ##1 !sel_run_i |-> !motor_en_o)
    else $error("motor powered during setup");

  a_locked_write: assert property ( // R2
    sel_run_i && wr_i && addr_i == `DDM_ADDR_PROT_POS
    |=> $stable(prot_pos_q))
    else $error("setting changed while running");

  a_auto_follow: assert property ( // R12
    sel_run_i && sel_auto_i && auto_w && ext_open_i && !ext_close_i
    |=> cmd_open_o)
    else $error("controller open not followed");

  a_hand_toggle: assert property ( // R5
    hand_w && sel_run_i && !sel_auto_i && tog_close_i && !tog_open_i
    |=> cmd_close_o && (slow_close_o == $past(tog_slow_i)))
    else $error("manual close not followed");

  a_both_hold: assert property ( // R21
    moving_w && src_open_w && src_close_w
    |=> !cmd_open_o && !cmd_close_o && ind_hold_o)
    else $error("door moved on conflicting commands");

  a_tune_learn: assert property ( // R9
    mode_q == ddm_pkg::DDM_HALT && !sel_run_i && tune_rise_w
    |=> learn_start_o ##1 !learn_start_o)
    else $error("tuning did not start learning");

  a_fault_clear: assert property ( // R10
    fault_monitor_o && rst_rise_w && !fault_i |=> !fault_monitor_o)
    else $error("fault not cleared by reset");

  a_fault_keep: assert property ( // R10
    fault_i |=> fault_monitor_o)
    else $error("fault not latched");

  a_edge_off: assert property ( // R19
    edge_set_w == `DDM_EDGE_OFF && !stall_hit_w
    |=> !door_reverse_request_o)
    else $error("reverse request with edge disabled");

  a_edge_sink: assert property ( // R20
    edge_set_w == `DDM_EDGE_SINK && !edge_sense_i
    |=> door_reverse_request_o)
    else $error("sinking edge not detected");

  a_prot_pos: assert property ( // R13
    door_pos_i <= prot_pos_q |=> door_protection_output_o)
    else $error("protection output missed");

  a_limit_learn: assert property ( // R16
    !learned_q |=> !closed_limit_output_o && !open_limit_output_o)
    else $error("limit before learning");

  c_auto_open: cover property (auto_w ##1 cmd_open_o);
  c_hand_slow: cover property (hand_w ##1 slow_close_o);
  c_learn_done: cover property (learn_start_o ##[1:20] ind_learned_o);
  c_reverse: cover property (cmd_close_o ##1 door_reverse_request_o);

endmodule

// [verification/ddm_ctrl_model.sv]
`timescale 1ns/1ps

// Elevator controller seen from the drive: it holds the four command
// lines and answers a reverse request by commanding open, at once or late.
module ddm_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [3:0] cmd_i,   // Wanted {heavy, slow, close, open}.
  input  wire logic       slow_i,  // High makes the reopen answer late.
  input  wire logic       rev_i,   // Reverse request from the drive.
  output logic            ext_open_o,
  output logic            ext_close_o,
  output logic            ext_slow_o,
  output logic            ext_heavy_o
);
  logic [2:0] wait_q;  // Cycles the reverse request has stood.
  logic [3:0] cmd_q;   // Command lines as driven.
  logic       reopen;  // The controller has decided to reopen.

  // A slow controller lets three cycles pass before it reopens.
  assign reopen = rev_i && (wait_q >= (slow_i ? 3'h3 : 3'h0));

  // Count how long the request stands and register the lines.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wait_q <= 3'h0;
      cmd_q  <= 4'h0;
    end
    else
    begin
      if (!rev_i)
        wait_q <= 3'h0;
      else if (wait_q != 3'h7)
        wait_q <= wait_q + 3'h1;
      // Reopening drops close and slow but keeps the heavy line.
      cmd_q <= reopen ? {cmd_i[3], 3'h1} : cmd_i;
    end
  end

  // Each command travels on its own discrete line.
  assign ext_open_o  = cmd_q[0];
  assign ext_close_o = cmd_q[1];
  assign ext_slow_o  = cmd_q[2];
  assign ext_heavy_o = cmd_q[3];
endmodule

// [verification/ddm_top_bench.sv]
`timescale 1ns/1ps
`include "ddm_regs.svh"

// Compares one value, counts it and reports a mismatch at once.
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module ddm_top_bench;
  // Clock, reset and software port.
  logic        clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rd;
  // Panel toggles {heavy, slim, slow, close, open}, selectors, tuning.
  logic [4:0]  pan = 5'h00;
  logic        sel_run_i = 1'b0, sel_auto_i = 1'b0;
  logic        tog_tune_i = 1'b0, tog_reset_i = 1'b0;
  // Controller wishes, its pace, and the lines the model drives.
  logic [3:0]  want = 4'h0;
  logic        ctl_slow = 1'b0;
  wire logic   ext_open_i, ext_close_i, ext_slow_i, ext_heavy_i;
  // Drive side status.
  logic        stall_rev_i = 1'b0, edge_sense_i = 1'b0;
  logic        fault_i = 1'b0, learn_done_i = 1'b0;
  logic [15:0] door_pos_i = 16'h0, learn_width_i = 16'h0;
  // Outputs of the block.
  logic        motor_en_o, cmd_open_o, cmd_close_o, slow_close_o;
  logic        slim_door_mode_o, heavy_door_o, learn_start_o;
  logic        door_protection_output_o, door_reverse_request_o;
  logic        closed_limit_output_o, open_limit_output_o;
  logic        ind_learning_o, ind_learned_o, ind_hold_o, ind_edge_o;
  logic        fault_monitor_o;
  int          errors = 0, n_compared = 0, cycles = 0;
  // Command cases {auto, ext heavy slow close open, panel bits}.
  logic [9:0]  cmd_tab [11] = '{10'h222, 10'h2c9, 10'h320, 10'h260,
    10'h280, 10'h041, 10'h026, 10'h009, 10'h012, 10'h023, 10'h044};
  // Reverse cases {setting, stall, light curtain, expected request}.
  logic [5:0]  rev_tab [10] = '{6'h04, 6'h0f, 6'h0a, 6'h11, 6'h12,
    6'h23, 6'h20, 6'h30, 6'h32, 6'h00};

  ddm_top u_dut (
    .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sel_run_i, .sel_auto_i, .tog_open_i(pan[0]), .tog_close_i(pan[1]),
    .tog_slow_i(pan[2]), .tog_slim_i(pan[3]), .tog_heavy_i(pan[4]),
    .tog_tune_i, .tog_reset_i, .ext_open_i, .ext_close_i, .ext_slow_i,
    .ext_heavy_i, .stall_rev_i, .edge_sense_i, .fault_i, .door_pos_i,
    .learn_done_i, .learn_width_i, .motor_en_o, .cmd_open_o, .cmd_close_o,
    .slow_close_o, .slim_door_mode_o, .heavy_door_o, .learn_start_o,
    .door_protection_output_o, .door_reverse_request_o,
    .closed_limit_output_o, .open_limit_output_o, .ind_learning_o,
    .ind_learned_o, .ind_hold_o, .ind_edge_o, .fault_monitor_o
  );

  ddm_ctrl_model u_ctrl (
    .clk_i, .srst_i, .cmd_i(want), .slow_i(ctl_slow),
    .rev_i(door_reverse_request_o), .ext_open_o(ext_open_i),
    .ext_close_o(ext_close_i), .ext_slow_o(ext_slow_i),
    .ext_heavy_o(ext_heavy_i)
  );

  // Clock of 5 ns period.
  always #2.5 clk_i = ~clk_i;

  // Cuts a hung run short.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      $display("MISMATCH run_length expected below 3000 seen %0d", cycles);
      give_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    $display("Compared %0d values, %0d errors", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Every task except look is entered and left just after a rising edge.
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Samples settled outputs half a cycle later.
  task look;
    @(negedge clk_i);
  endtask

  // One write cycle; the strobe drops before a new one may start.
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
    cyc(1);
  endtask

  // One read cycle; the data stand only in the following cycle.
  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    cyc(1);
    rd_i <= 1'b0;
    look;
    d = rdata_o;
    cyc(1);
  endtask

  // Moves the selectors and lets the mode settle.
  task set_sel(input logic run, input logic auto);
    sel_run_i <= run;
    sel_auto_i <= auto;
    cyc(3);
  endtask

  // Expected {hold, slim, heavy, slow, close, open} for one case.
  // Hold shows whenever the door is told to move in neither direction.
  function automatic logic [5:0] expect_cmd(input logic [9:0] e);
    logic [4:0] s;
    s = e[9] ? {e[8], 1'b0, e[7:5]} : e[4:0];
    return {~(s[0] ^ s[1]), ~e[9] & e[3], s[4], s[1] & ~s[0] & s[2],
            s[1] & ~s[0], s[0] & ~s[1]};
  endfunction

  // State right after reset, and the setup position holding the motor.
  task t_reset;
    look;
    `CHK("motor_en", 1'b0, motor_en_o)
    `CHK("closed_limit", 1'b0, closed_limit_output_o)
    `CHK("protection", 1'b0, door_protection_output_o)
    cyc(1);
    bus_rd(`DDM_ADDR_PROT_POS, rd);
    `CHK("prot_pos", 32'h10, rd)
    bus_rd(`DDM_ADDR_REV_CFG, rd);
    `CHK("rev_cfg", 32'h0, rd)
    want <= 4'h1;
    pan <= 5'h01;
    cyc(3);
    look;
    `CHK("motor_en", 1'b0, motor_en_o)
    `CHK("cmd_open", 1'b0, cmd_open_o)
    cyc(1);
    want <= 4'h0;
    pan <= 5'h00;
  endtask

  // Settings lock in run, plus the protection threshold boundary.
  task t_lock;
    bus_wr(`DDM_ADDR_PROT_POS, 32'h1234);
    bus_rd(`DDM_ADDR_PROT_POS, rd);
    `CHK("prot_pos", 32'h1234, rd)
    set_sel(1'b1, 1'b1);
    bus_wr(`DDM_ADDR_PROT_POS, 32'h0055);
    bus_wr(`DDM_ADDR_REV_CFG, 32'h1);
    bus_rd(`DDM_ADDR_PROT_POS, rd);
    `CHK("prot_pos", 32'h1234, rd)
    bus_rd(`DDM_ADDR_REV_CFG, rd);
    `CHK("rev_cfg", 32'h0, rd)
    bus_rd(8'h3c, rd);
    `CHK("unmapped", 32'h0, rd)
    door_pos_i <= 16'h1234;
    cyc(1);
    look;
    `CHK("protection", 1'b1, door_protection_output_o)
    cyc(1);
    door_pos_i <= 16'h1235;
    cyc(1);
    look;
    `CHK("protection", 1'b0, door_protection_output_o)
    cyc(1);
  endtask

  // Commands from the controller in automatic, from the panel in manual.
  task t_cmds;
    logic [5:0] x;
    for (int i = 0; i < 11; i++)
    begin
      set_sel(1'b1, cmd_tab[i][9]);
      want <= cmd_tab[i][8:5];
      pan <= cmd_tab[i][4:0];
      cyc(2);
      look;
      x = expect_cmd(cmd_tab[i]);
      `CHK("motor_en", 1'b1, motor_en_o)
      `CHK("cmd_open", x[0], cmd_open_o)
      `CHK("cmd_close", x[1], cmd_close_o)
      `CHK("slow_close", x[2], slow_close_o)
      `CHK("heavy", x[3], heavy_door_o)
      `CHK("slim", x[4], slim_door_mode_o)
      `CHK("hold", x[5], ind_hold_o)
      cyc(1);
    end
    want <= 4'h0;
    pan <= 5'h00;
  endtask

  // Width learning from setup, then limits at the learned ends.
  task t_learn;
    int k;
    logic [15:0] pos [6];
    pos = '{16'h0, 16'h2, 16'h3, 16'hfd, 16'hfe, 16'h100};
    set_sel(1'b0, 1'b0);
    tog_tune_i <= 1'b1;
    k = 0;
    look;
    while (learn_start_o !== 1'b1 && k < 8)
    begin
      cyc(1);
      look;
      k++;
    end
    `CHK("learn_start", 1'b1, learn_start_o)
    cyc(1);
    look;
    `CHK("learn_start", 1'b0, learn_start_o)
    `CHK("learning", 1'b1, ind_learning_o)
    cyc(1);
    learn_width_i <= 16'h0100;
    learn_done_i <= 1'b1;
    cyc(1);
    learn_done_i <= 1'b0;
    tog_tune_i <= 1'b0;
    look;
    `CHK("learned", 1'b1, ind_learned_o)
    cyc(1);
    bus_rd(`DDM_ADDR_WIDTH, rd);
    `CHK("width", 32'h100, rd)
    for (int i = 0; i < 6; i++)
    begin
      door_pos_i <= pos[i];
      cyc(1);
      look;
      `CHK("closed_limit", i < 2, closed_limit_output_o)
      `CHK("open_limit", i > 3, open_limit_output_o)
      cyc(1);
    end
  endtask

  // Fault latch: idle reset press, set beating clear, then a clear.
  task t_fault;
    tog_reset_i <= 1'b1;
    cyc(1);
    tog_reset_i <= 1'b0;
    look;
    `CHK("fault_monitor", 1'b0, fault_monitor_o)
    cyc(1);
    fault_i <= 1'b1;
    cyc(1);
    fault_i <= 1'b0;
    cyc(3);
    look;
    `CHK("fault_monitor", 1'b1, fault_monitor_o)
    cyc(1);
    fault_i <= 1'b1;
    tog_reset_i <= 1'b1;
    cyc(1);
    fault_i <= 1'b0;
    tog_reset_i <= 1'b0;
    look;
    `CHK("fault_monitor", 1'b1, fault_monitor_o)
    cyc(1);
    tog_reset_i <= 1'b1;
    cyc(1);
    tog_reset_i <= 1'b0;
    look;
    `CHK("fault_monitor", 1'b0, fault_monitor_o)
    cyc(1);
  endtask

  // Reverse request sources under every edge setting.
  task t_reverse;
    logic e;
    for (int i = 0; i < 10; i++)
    begin
      bus_wr(`DDM_ADDR_REV_CFG, {29'h0, rev_tab[i][5:3]});
      stall_rev_i <= rev_tab[i][2];
      edge_sense_i <= rev_tab[i][1];
      cyc(1);
      look;
      `CHK("reverse", rev_tab[i][0], door_reverse_request_o)
      e = rev_tab[i][0] & ~(rev_tab[i][3] & rev_tab[i][2]);
      `CHK("edge_led", e, ind_edge_o)
      cyc(1);
    end
    edge_sense_i <= 1'b1;
    cyc(1);
    bus_wr(`DDM_ADDR_REV_CFG, 32'h2);
  endtask

  // A broken curtain while closing only flags; the controller reopens.
  task t_reopen;
    int k;
    set_sel(1'b1, 1'b1);
    ctl_slow <= 1'b1;
    want <= 4'h2;
    cyc(3);
    edge_sense_i <= 1'b0;
    k = 0;
    look;
    while (door_reverse_request_o !== 1'b1 && k < 8)
    begin
      cyc(1);
      look;
      k++;
    end
    `CHK("reverse", 1'b1, door_reverse_request_o)
    `CHK("cmd_open", 1'b0, cmd_open_o)
    `CHK("cmd_close", 1'b1, cmd_close_o)
    while (cmd_open_o !== 1'b1 && k < 16)
    begin
      cyc(1);
      look;
      k++;
    end
    `CHK("cmd_open", 1'b1, cmd_open_o)
    cyc(1);
    edge_sense_i <= 1'b1;
    want <= 4'h0;
    cyc(4);
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn.
  initial
  begin
    cyc(4);
    srst_i <= 1'b0;
    t_reset;
    t_lock;
    t_cmds;
    t_learn;
    t_fault;
    t_reverse;
    t_reopen;
    give_verdict();
  end
endmodule
